// File: hdl/l2cp_consts.svh
`ifndef L2CP_CONSTS_SVH
`define L2CP_CONSTS_SVH

// ----------------------------------------
// Request sources, index 0 wins
// ----------------------------------------
`define L2CP_SRC_SNOOP   0
`define L2CP_SRC_RELOAD  1
`define L2CP_SRC_L2CO    2
`define L2CP_SRC_PUSH    3
`define L2CP_SRC_STMISS  4
`define L2CP_SRC_LDMISS  5
`define L2CP_SRC_IMISS   6
`define L2CP_SRC_L1CO    7
`define L2CP_NUM_SRC     8

// ----------------------------------------
// Line, forced bus attributes {W,I,M}
// ----------------------------------------
`define L2CP_LINE_BYTES  6'h20
`define L2CP_WIM_READ    3'h0
`define L2CP_WIM_INHIB   3'h2
`define L2CP_WIM_WRITE   3'h4

// ----------------------------------------
// Replacement generator
// ----------------------------------------
`define L2CP_LFSR_SEED   16'hace1
`define L2CP_TAP_A       15
`define L2CP_TAP_B       13
`define L2CP_TAP_C       12
`define L2CP_TAP_D       10
`define L2CP_WAY_B0      4
`define L2CP_WAY_B1      9
`define L2CP_WAY_B2      15
`define L2CP_CNT_RESET   3'h0
`define L2CP_WAY_RESET   3'h0

`endif

// File: hdl/l2cp_pkg.sv
package l2cp_pkg;

  typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} l2cp_mesi_t;

  typedef enum logic {ST_IDLE, ST_WAIT} l2cp_fsm_t;

  typedef struct packed {
    logic [2:0]  cnt;
    logic [15:0] lfsr;
    logic [2:0]  hist0;
    logic [2:0]  hist1;
    logic [2:0]  hist2;
  } l2cp_rep_t;

  typedef struct packed {
    l2cp_fsm_t    fsm;
    logic [7:0]   grant;
    logic         busRead;
    logic         busRwitm;
    logic         busWrite;
    logic [2:0]   busWim;
    logic [31:0]  busByteEn;
    logic [255:0] busData;
    logic [255:0] blockData;
    logic         l2Write;
    l2cp_mesi_t   l2State;
    logic         l3Write;
    l2cp_mesi_t   l3State;
    logic         l3Flush;
    logic         l3Castout;
    logic         victimCastout;
    logic         sqPush;
    logic         l1RespValid;
    l2cp_mesi_t   l1Resp;
    logic         critForward;
    logic         scRetry;
    logic [4:0]   fwdAttr;
    logic [2:0]   way;
    logic         pendL2;
    logic         pendL3;
    logic         pendRwitm;
    logic         pendTouch;
    logic         pendAbort;
    l2cp_mesi_t   pendInitL2;
    l2cp_mesi_t   pendInitL3;
  } l2cp_pol_t;

endpackage : l2cp_pkg

// File: hdl/l2cp_arbiter.sv
`timescale 1ns/1ps

module l2cp_arbiter #(
  parameter int N = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] grant
);

  // ----------------------------------------
  // Fixed priority, lowest index first
  // ----------------------------------------
  assign grant = req & (~req + N'(1)); // R1

  onlyOne_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $onehot0(grant)) else $error("more than one grant"); // R1
  snoopFirst_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    req[0] |-> grant == N'(1)) else $error("snoop not served first"); // R1

endmodule : l2cp_arbiter

// File: hdl/l2cp_repl_sel.sv
`timescale 1ns/1ps
`include "l2cp_consts.svh"

module l2cp_repl_sel (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       replMode,
  input  wire logic       take,
  output logic      [2:0] way
);

  l2cp_pkg::l2cp_rep_t s;
  l2cp_pkg::l2cp_rep_t next_s;
  logic [2:0]          cand;

  // ----------------------------------------
  // Skip any of the last three victims
  // ----------------------------------------
  function automatic logic [2:0] l2cp_pick(input logic [2:0] c, input logic [2:0] h0,
                                           input logic [2:0] h1, input logic [2:0] h2);
    logic [2:0] w;
    l2cp_pick = c;
    for (int k = 3; k >= 0; k--) begin
      w = c + 3'(k); // R24
      if (w != h0 && w != h1 && w != h2) begin
        l2cp_pick = w; // R16
      end
    end
  endfunction : l2cp_pick

  assign cand = replMode ? s.cnt // R14
              : {s.lfsr[`L2CP_WAY_B2], s.lfsr[`L2CP_WAY_B1], s.lfsr[`L2CP_WAY_B0]}; // R15
  assign way  = l2cp_pick(cand, s.hist0, s.hist1, s.hist2);

  always_comb begin
    next_s      = s;
    next_s.cnt  = s.cnt + 3'h1; // R14
    // Both sources free-run so a mode change needs no warm-up
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[`L2CP_TAP_A] ^ s.lfsr[`L2CP_TAP_B]
                   ^ s.lfsr[`L2CP_TAP_C] ^ s.lfsr[`L2CP_TAP_D]}; // R15 R23
    if (take) begin
      // Three deep: covers the misses still in lookup
      next_s.hist0 = way; // R17
      next_s.hist1 = s.hist0;
      next_s.hist2 = s.hist1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s.cnt   <= `L2CP_CNT_RESET;
      s.lfsr  <= `L2CP_LFSR_SEED; // R23
      s.hist0 <= `L2CP_WAY_RESET;
      s.hist1 <= `L2CP_WAY_RESET;
      s.hist2 <= `L2CP_WAY_RESET;
    end else begin
      s <= next_s;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  countStep_a: assert property ($past(rstn) |-> s.cnt == $past(s.cnt) + 3'h1)
    else $error("counter did not advance"); // R14
  lfsrLive_a: assert property (s.lfsr != 16'h0000)
    else $error("generator stuck at zero"); // R15
  noRepeat_a: assert property (take |-> way != s.hist0 && way != s.hist1 && way != s.hist2)
    else $error("recent victim chosen again"); // R16

endmodule : l2cp_repl_sel

// File: hdl/l2cp_policy.sv
`timescale 1ns/1ps
`include "l2cp_consts.svh"
// ----------------------------------------
// Notes on behaviour
// R1 - Serve snoop, reload, L2 castout, push, store/load/fetch miss, L1 castout.
// R2 - Reloaded line is written and marked from the snoop response.
// R3 - Modified victim is cast out to L3 at miss time, not reload.
// R4 - Fetch miss allocates L2 only if L2 enabled and not data-only.
// R5 - Fetch miss allocates L3 only if L3 enabled and not data-only.
// R6 - Data miss allocates L2 only if L2 enabled and not instruction-only.
// R7 - Data miss allocates L3 only if L3 enabled and not instruction-only.
// R8 - Store hitting shared L2 issues read-intent-modify, keeps and reloads line. Code takes the line from L3 instead, with no bus, when L3 is E or M.
// R9 - L1 castout never allocates L2; a hit writes the existing line.
// R10 - Transient accesses never allocate; hits still update state.
// R11 - Write-through hit merges bytes; whole block to L2 and store queue.
// R12 - Write-through L2 miss under 32 bytes flushes the L3 block first.
// R13 - Bus gets only the store's own bytes for write-through.
// R14 - Counter mode: three-bit counter steps each clock, picks the way.
// R15 - Generator mode: 16-stage shifter, stages 4, 9, 15 give the way.
// R16 - Way matching one of last three choices gets one to three added.
// R17 - History covers the three misses in flight during lookup.
// R18 - Abandoned allocation leaves the line at its initial state.
// R19 - Store-conditional losing reservation retries as a load; bus sets response.
// R20 - Request attributes forwarded; bus requests carry forced attribute values.
// R21 - Double miss reads bus, forwards critical data except touch.
// R22 - L2 miss with L3 hit: no bus, reload L2 as shared or exclusive. Code still sends a store to the bus unless L3 is E or M.
// R23 - Generator taps and nonzero seed chosen here.
// R24 - Adjusted way wraps modulo eight.

module l2cp_policy (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     reqSnoop,
  input  wire logic                     reqReload,
  input  wire logic                     reqL2Castout,
  input  wire logic                     reqPush,
  input  wire logic                     reqStoreMiss,
  input  wire logic                     reqLoadMiss,
  input  wire logic                     reqInstrMiss,
  input  wire logic                     reqL1Castout,
  input  wire logic                     attrWt,
  input  wire logic                     attrInhibit,
  input  wire logic                     attrCoherent,
  input  wire logic                     attrAtomic,
  input  wire logic                     attrTransient,
  input  wire logic                     reqTouch,
  input  wire logic                     reqScLost,
  input  wire logic [5:0]               reqBytes,
  input  wire logic [31:0]              reqByteEn,
  input  wire logic [255:0]             reqData,
  input  wire logic [255:0]             lineData,
  input  wire l2cp_pkg::l2cp_mesi_t     reqL2State,
  input  wire l2cp_pkg::l2cp_mesi_t     reqL3State,
  input  wire logic                     victimModified,
  input  wire logic                     reloadShared,
  input  wire logic                     allocAbort,
  input  wire logic                     second_level_enable,
  input  wire logic                     second_level_data_only,
  input  wire logic                     second_level_instr_only,
  input  wire logic                     third_level_enable,
  input  wire logic                     third_level_data_only,
  input  wire logic                     third_level_instr_only,
  input  wire logic                     replacement_mode_select,
  output logic [7:0]                    grant,
  output logic                          busRead,
  output logic                          busRwitm,
  output logic                          busWrite,
  output logic [2:0]                    busWim,
  output logic [31:0]                   busByteEn,
  output logic [255:0]                  busData,
  output logic [255:0]                  blockData,
  output logic                          l2Write,
  output l2cp_pkg::l2cp_mesi_t          l2State,
  output logic [2:0]                    l2Way,
  output logic                          l3Write,
  output l2cp_pkg::l2cp_mesi_t          l3State,
  output logic                          l3Flush,
  output logic                          l3Castout,
  output logic                          victimCastout,
  output logic                          sqPush,
  output logic                          l1RespValid,
  output l2cp_pkg::l2cp_mesi_t          l1Resp,
  output logic                          critForward,
  output logic                          scRetry,
  output logic [4:0]                    fwdAttr,
  output logic                          missBusy
);

  l2cp_pkg::l2cp_pol_t s;
  l2cp_pkg::l2cp_pol_t next_s;
  logic [7:0]          reqVec;
  logic [7:0]          grantVec;
  logic [2:0]          replWay;
  logic                replTake;
  logic                waiting;
  logic                isInstr;
  logic                l2Hit;
  logic                l3Hit;
  logic                l3Own;
  logic                okL2;
  logic                okL3;

  // ----------------------------------------
  // Byte-enable merge of store into line
  // ----------------------------------------
  function automatic logic [255:0] l2cp_merge(input logic [255:0] line,
                                              input logic [255:0] data,
                                              input logic [31:0]  be);
    l2cp_merge = line;
    for (int b = 0; b < 32; b++) begin
      if (be[b]) begin
        l2cp_merge[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction : l2cp_merge

  // ----------------------------------------
  // Arbitration and replacement
  // ----------------------------------------
  // One miss outstanding; L1 requests wait, the just-granted source is masked
  assign waiting = (s.fsm == l2cp_pkg::ST_WAIT);
  assign reqVec  = {reqL1Castout & ~waiting, reqInstrMiss & ~waiting, reqLoadMiss & ~waiting,
                    reqStoreMiss & ~waiting, reqPush, reqL2Castout, reqReload & waiting,
                    reqSnoop} & ~s.grant;

  l2cp_arbiter #(
    .N     (`L2CP_NUM_SRC)
  ) u_arb (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .req     (reqVec),
    .grant   (grantVec)
  );

  l2cp_repl_sel u_repl (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .replMode (replacement_mode_select),
    .take     (replTake),
    .way      (replWay)
  );

  assign isInstr = grantVec[`L2CP_SRC_IMISS];
  assign l2Hit   = (reqL2State != l2cp_pkg::MESI_I);
  assign l3Hit   = (reqL3State != l2cp_pkg::MESI_I);
  assign l3Own   = (reqL3State == l2cp_pkg::MESI_E) || (reqL3State == l2cp_pkg::MESI_M);
  assign okL2    = second_level_enable & ~attrTransient
                 & (isInstr ? ~second_level_data_only : ~second_level_instr_only); // R4 R6 R10
  assign okL3    = third_level_enable & ~attrTransient
                 & (isInstr ? ~third_level_data_only : ~third_level_instr_only); // R5 R7 R10

  // ----------------------------------------
  // Policy decisions
  // ----------------------------------------
  always_comb begin
    next_s               = s;
    replTake             = 1'b0;
    next_s.grant         = grantVec;
    next_s.busRead       = 1'b0;
    next_s.busRwitm      = 1'b0;
    next_s.busWrite      = 1'b0;
    next_s.l2Write       = 1'b0;
    next_s.l3Write       = 1'b0;
    next_s.l3Flush       = 1'b0;
    next_s.l3Castout     = 1'b0;
    next_s.victimCastout = 1'b0;
    next_s.sqPush        = 1'b0;
    next_s.l1RespValid   = 1'b0;
    next_s.critForward   = 1'b0;
    next_s.scRetry       = 1'b0;
    if (|grantVec[7:4]) begin
      next_s.fwdAttr = {attrWt, attrInhibit, attrCoherent, attrAtomic, attrTransient}; // R20
      next_s.busByteEn = reqByteEn; // R13
      next_s.busData   = reqData; // R13
    end
    case (s.fsm)
      l2cp_pkg::ST_IDLE: begin
        // A shared line stays allocated and is refilled in place
        next_s.pendL2 = okL2; // R8 R10
        next_s.pendL3 = okL3; // R10
        if (|grantVec[7:4] && attrInhibit) begin
          next_s.busRead  = ~grantVec[`L2CP_SRC_STMISS] & ~grantVec[`L2CP_SRC_L1CO];
          next_s.busWrite = grantVec[`L2CP_SRC_STMISS] | grantVec[`L2CP_SRC_L1CO];
          next_s.busWim   = `L2CP_WIM_INHIB; // R20
        end else if (grantVec[`L2CP_SRC_L1CO]) begin
          if (l2Hit && second_level_enable) begin
            next_s.l2Write   = 1'b1; // R9
            next_s.l2State   = l2cp_pkg::MESI_M;
            next_s.blockData = reqData;
          end else begin
            next_s.l3Castout = 1'b1; // R9
          end
        end else if (grantVec[`L2CP_SRC_STMISS] && attrWt) begin
          next_s.busWrite  = 1'b1;
          next_s.busWim    = `L2CP_WIM_WRITE;
          if (l2Hit) begin
            next_s.blockData = l2cp_merge(lineData, reqData, reqByteEn); // R11
            next_s.l2Write   = 1'b1; // R11
            next_s.l2State   = reqL2State;
            next_s.sqPush    = 1'b1; // R11
          end else if (reqBytes < `L2CP_LINE_BYTES) begin
            next_s.l3Flush = 1'b1; // R12
          end
        end else if (|grantVec[6:4]) begin
          next_s.l1RespValid = 1'b1;
          if (grantVec[`L2CP_SRC_STMISS] && attrAtomic && reqScLost) begin
            // Reservation gone: the atomic claim retries itself as a plain read
            next_s.scRetry   = 1'b1; // R19
            next_s.busRead   = 1'b1; // R19
            next_s.busWim    = `L2CP_WIM_READ;
            next_s.pendRwitm = 1'b0;
          end else if (grantVec[`L2CP_SRC_STMISS] && (reqL2State == l2cp_pkg::MESI_E ||
                       reqL2State == l2cp_pkg::MESI_M)) begin
            next_s.l1Resp = l2cp_pkg::MESI_E;
          end else if (!grantVec[`L2CP_SRC_STMISS] && l2Hit) begin
            next_s.l1Resp = (reqL2State == l2cp_pkg::MESI_S) ? l2cp_pkg::MESI_S
                                                            : l2cp_pkg::MESI_E;
          end else if (grantVec[`L2CP_SRC_STMISS] ? l3Own : l3Hit) begin
            // Lower cache supplies the line: no bus traffic
            next_s.l1Resp = (!grantVec[`L2CP_SRC_STMISS] && reqL3State == l2cp_pkg::MESI_S)
                          ? l2cp_pkg::MESI_S : l2cp_pkg::MESI_E; // R22
            next_s.l2Write = okL2; // R22
            next_s.l2State = next_s.l1Resp; // R22
            next_s.way     = replWay;
            replTake       = okL2 & ~l2Hit;
            next_s.victimCastout = okL2 & ~l2Hit & victimModified; // R3
          end else begin
            next_s.busRead  = ~grantVec[`L2CP_SRC_STMISS]; // R21
            next_s.busRwitm = grantVec[`L2CP_SRC_STMISS]; // R8
            next_s.busWim   = `L2CP_WIM_READ; // R20
            next_s.pendRwitm = grantVec[`L2CP_SRC_STMISS];
          end
          if (next_s.busRead || next_s.busRwitm) begin
            next_s.fsm        = l2cp_pkg::ST_WAIT;
            // The answer to L1 comes with the reload, not now
            next_s.l1RespValid = 1'b0; // R19
            next_s.pendTouch  = reqTouch;
            next_s.pendAbort  = 1'b0;
            next_s.pendInitL2 = reqL2State;
            next_s.pendInitL3 = reqL3State;
            next_s.way        = replWay;
            replTake          = okL2 & ~l2Hit; // R17
            next_s.victimCastout = okL2 & ~l2Hit & victimModified; // R3
          end
        end
      end
      l2cp_pkg::ST_WAIT: begin
        next_s.pendAbort = s.pendAbort | allocAbort;
        if (grantVec[`L2CP_SRC_RELOAD]) begin
          next_s.fsm         = l2cp_pkg::ST_IDLE;
          next_s.l1RespValid = 1'b1;
          next_s.l1Resp      = (reloadShared && !s.pendRwitm) ? l2cp_pkg::MESI_S
                                                             : l2cp_pkg::MESI_E; // R2 R19
          next_s.critForward = ~s.pendTouch & ~s.pendRwitm; // R21
          next_s.l2Write     = s.pendL2; // R2
          next_s.l3Write     = s.pendL3;
          if (s.pendAbort || allocAbort) begin
            next_s.l2State = s.pendInitL2; // R18
            next_s.l3State = s.pendInitL3; // R18
          end else begin
            next_s.l2State = next_s.l1Resp; // R2
            next_s.l3State = next_s.l1Resp; // R21
          end
        end
      end
      default: begin
        next_s.fsm = l2cp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign grant         = s.grant;
  assign busRead       = s.busRead;
  assign busRwitm      = s.busRwitm;
  assign busWrite      = s.busWrite;
  assign busWim        = s.busWim;
  assign busByteEn     = s.busByteEn;
  assign busData       = s.busData;
  assign blockData     = s.blockData;
  assign l2Write       = s.l2Write;
  assign l2State       = s.l2State;
  assign l2Way         = s.way;
  assign l3Write       = s.l3Write;
  assign l3State       = s.l3State;
  assign l3Flush       = s.l3Flush;
  assign l3Castout     = s.l3Castout;
  assign victimCastout = s.victimCastout;
  assign sqPush        = s.sqPush;
  assign l1RespValid   = s.l1RespValid;
  assign l1Resp        = s.l1Resp;
  assign critForward   = s.critForward;
  assign scRetry       = s.scRetry;
  assign fwdAttr       = s.fwdAttr;
  assign missBusy      = waiting;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence reloadAbort_s;
    waiting && grantVec[1] && (s.pendAbort || allocAbort) && s.pendL2;
  endsequence

  sequence wtSmallMiss_s;
    !waiting && grantVec[4] && attrWt && !attrInhibit && !l2Hit && reqBytes < 6'h20;
  endsequence

  smallFlush_a: assert property (wtSmallMiss_s |=> l3Flush && busWrite)
    else $error("short write-through miss not flushed"); // R12
  busBytes_a: assert property (!waiting && grantVec[4] && attrWt && !attrInhibit
    |=> busByteEn == $past(reqByteEn) && busData == $past(reqData))
    else $error("bus carried merged block"); // R13
  instrAlloc_a: assert property (!waiting && grantVec[6] && !attrInhibit && !l2Hit
    && second_level_data_only |=> !l2Write && !s.pendL2)
    else $error("data-only L2 allocated a fetch"); // R4
  transientAlloc_a: assert property (!waiting && |grantVec[6:4] && attrTransient
    |=> !s.pendL2 && !s.pendL3 && !victimCastout)
    else $error("transient access allocated"); // R10
  victimEarly_a: assert property (waiting && grantVec[1] |=> !victimCastout && !waiting)
    else $error("victim cast out at reload"); // R3
  abortState_a: assert property (reloadAbort_s |=> l2Write && l2State == $past(s.pendInitL2))
    else $error("abandoned allocation changed state"); // R18
  castoutMiss_a: assert property (!waiting && grantVec[7] && !attrInhibit && !l2Hit
    |=> l3Castout && !l2Write)
    else $error("L1 castout allocated in L2"); // R9
  l3HitNoBus_a: assert property (!waiting && grantVec[5] && !attrInhibit && !l2Hit && l3Hit
    |=> !busRead && !busRwitm && l1RespValid)
    else $error("L3 hit went to the bus"); // R22

endmodule : l2cp_policy

// File: bench/l2cp_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: lower cache and bus answer reads
// ----------------------------------------
module l2cp_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       busRead,
  input  wire logic       busRwitm,
  input  wire logic [7:0] grant,
  output logic            reqReload,
  output logic            reloadShared
);
  int cnt = 0;
  initial begin
    reqReload = 1'b0;
    reloadShared = 1'b0;
  end
  // Delay 1 to 7 cycles, so both prompt and slow reloads occur
  always @(posedge sys_clk) begin
    if (rstn && (busRead || busRwitm)) cnt <= 1 + $urandom_range(6);
    else if (cnt > 0) cnt <= cnt - 1;
    if (!rstn || grant[1]) reqReload <= 1'b0;
    else if (cnt == 1) reqReload <= 1'b1;
    // Response line carries noise outside a reload
    if (!reqReload) reloadShared <= $urandom_range(1);
  end
endmodule : l2cp_far_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rstn, reqSnoop, reqReload, reqL2Castout, reqPush, reqStoreMiss, reqLoadMiss;
  logic reqInstrMiss, reqL1Castout, attrWt, attrInhibit, attrCoherent, attrAtomic, attrTransient;
  logic reqTouch, reqScLost, victimModified, reloadShared, allocAbort, second_level_enable;
  logic second_level_data_only, second_level_instr_only, third_level_enable, third_level_data_only;
  logic third_level_instr_only, replacement_mode_select, busRead, busRwitm, busWrite, l2Write;
  logic l3Write, l3Flush, l3Castout, victimCastout, sqPush, l1RespValid, critForward, scRetry;
  logic missBusy, shr, a2, a3, ab, sc, ih;
  logic [2:0] busWim, l2Way;
  logic [4:0] fwdAttr;
  logic [5:0] reqBytes;
  logic [7:0] grant;
  logic [31:0] reqByteEn, busByteEn;
  logic [255:0] reqData, lineData, busData, blockData, m;
  l2cp_pkg::l2cp_mesi_t reqL2State, reqL3State, l2State, l3State, l1Resp, rs;
  int n_errors = 0, checked = 0, k, s, n;
  int w[$] = '{0, 0, 0};
  l2cp_policy l2cp_policy_i (.*);
  l2cp_far_model l2cp_far_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (reqReload) shr <= reloadShared;
  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Request stands for one taking edge only
  task automatic go(input logic [7:0] r);
    {reqL1Castout, reqInstrMiss, reqLoadMiss, reqStoreMiss, reqPush, reqL2Castout} <= r[7:2];
    reqSnoop <= r[0];
    @(posedge sys_clk);
    {reqL1Castout, reqInstrMiss, reqLoadMiss, reqStoreMiss, reqPush, reqL2Castout} <= 6'h0;
    reqSnoop <= 1'b0;
    #1;
  endtask : go
  initial begin
    #20_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    {rstn, reqSnoop, reqL2Castout, reqPush, reqStoreMiss, reqLoadMiss, reqInstrMiss} = 7'h0;
    {reqL1Castout, attrWt, attrInhibit, attrCoherent, attrAtomic, attrTransient, reqTouch} = 7'h0;
    {reqScLost, victimModified, allocAbort, second_level_enable, second_level_data_only} = 5'h2;
    {second_level_instr_only, third_level_enable, third_level_data_only} = 3'h0;
    {third_level_instr_only, replacement_mode_select} = 2'h0;
    {reqBytes, reqByteEn, reqData, lineData} = '0;
    reqL2State = l2cp_pkg::MESI_I;
    reqL3State = l2cp_pkg::MESI_I;
    void'($urandom(32'hcbc0_b371));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    // ----------------------------------------
    // Priority, all L1 side accesses hitting
    // ----------------------------------------
    repeat (24) begin
      s = $urandom_range(255) & 8'hfd;
      if (s == 0) s = 128;
      @(posedge sys_clk);
      reqL2State <= $urandom_range(1) ? l2cp_pkg::MESI_I : l2cp_pkg::MESI_E;
      reqL3State <= l2cp_pkg::MESI_E;
      go(s[7:0]);
      chk("grant", grant, s & -s);
      ab = reqL2State == l2cp_pkg::MESI_I;
      if (s == 128) chk("castout", {l2Write, l3Castout}, {!ab, ab});
      rs = l2cp_pkg::MESI_E;
      if ((s & -s) inside {16, 32, 64} && ab) begin
        chk("l3 hit", {busRead, busRwitm, l1RespValid, l2Write, l1Resp}, {4'h3, rs});
        chk("l3 way", l2Way == w[0] || l2Way == w[1] || l2Way == w[2], 1'b0);
        w = {int'(l2Way), w[0:1]};
      end
    end
    // ----------------------------------------
    // Misses with reload from the far side
    // ----------------------------------------
    repeat (24) begin
      s = 4 + $urandom_range(2);
      @(posedge sys_clk);
      {second_level_enable, second_level_data_only, second_level_instr_only, third_level_enable,
       third_level_data_only, third_level_instr_only, replacement_mode_select, attrTransient,
       victimModified} <= 9'($urandom);
      ab = $urandom_range(3) == 0;
      allocAbort <= ab;
      sc = s == 4 && $urandom_range(1);
      {attrAtomic, reqScLost} <= {2{sc}};
      reqTouch <= (s == 5) && $urandom_range(1);
      reqL2State <= (s == 4 && $urandom_range(1)) ? l2cp_pkg::MESI_S : l2cp_pkg::MESI_I;
      reqL3State <= l2cp_pkg::MESI_I;
      go(8'h1 << s);
      a2 = second_level_enable && !attrTransient
           && (s == 6 ? !second_level_data_only : !second_level_instr_only);
      a3 = third_level_enable && !attrTransient
           && (s == 6 ? !third_level_data_only : !third_level_instr_only);
      chk("bus", {scRetry, busRead, busRwitm, busWim, missBusy, l1RespValid},
          {sc, s != 4 || sc, s == 4 && !sc, 5'h2});
      chk("victim", victimCastout, victimModified && a2 && reqL2State == 0);
      chk("way", l2Way == w[0] || l2Way == w[1] || l2Way == w[2], 1'b0);
      if (a2 && reqL2State == 0) w = {int'(l2Way), w[0:1]};
      for (k = 0; k < 40 && grant[1] !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      rs = ((s == 4 && !sc) || !shr) ? l2cp_pkg::MESI_E : l2cp_pkg::MESI_S;
      chk("resp", {l1RespValid, l1Resp, missBusy}, {1'b1, rs, 1'b0});
      if (s != 4 || sc) chk("crit", critForward, !reqTouch);
      if (!ab) chk("fill", {l2Write, l3Write}, {a2, a3});
      if (a2) chk("l2 state", l2State, ab ? reqL2State : rs);
      if (a3 && !ab) chk("l3 state", l3State, rs);
      allocAbort <= 1'b0;
    end
    // ----------------------------------------
    // Write-through stores
    // ----------------------------------------
    repeat (10) begin
      n = 1 + $urandom_range(31);
      ih = $urandom_range(3) == 0;
      @(posedge sys_clk);
      for (k = 0; k < 8; k++) begin
        reqData[k*32+:32] <= $urandom;
        lineData[k*32+:32] <= $urandom;
      end
      {attrWt, attrInhibit, attrTransient, attrAtomic, reqScLost} <= {1'b1, ih, 3'h0};
      {reqBytes, reqByteEn} <= {n[5:0], 32'hffff_ffff >> (32 - n)};
      reqL2State <= $urandom_range(1) ? l2cp_pkg::MESI_E : l2cp_pkg::MESI_I;
      go(8'h10);
      ab = reqL2State == l2cp_pkg::MESI_E;
      for (k = 0; k < 32; k++) m[k*8+:8] = {8{reqByteEn[k]}};
      chk("wt bus", {busWrite, busWim, fwdAttr, busByteEn},
          {1'b1, ih ? 3'h2 : 3'h4, 1'b1, ih, 3'h0, reqByteEn});
      chk("wt data", busData, reqData);
      chk("wt fill", {l2Write, sqPush, l3Flush && !ab},
          {ab && !ih, ab && !ih, !ab && !ih && n < 32});
      if (ab && !ih) chk("merge", blockData, (lineData & ~m) | (reqData & m));
    end
    give_verdict();
  end
endmodule : testbench
